// [logic/frpg_fault_supervisor.sv]
module frpg_fault_supervisor #(
    parameter int unsigned RAMP_UNIT_CYCLES = frpg_pkg::RAMP_UNIT_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_converter_control_input,
    input wire logic i_ot_fault_det,
    input wire logic i_ot_cooled_det,
    input wire logic i_ot_warn_det,
    input wire logic i_bandgap_ot_det,
    input wire logic i_ls_oc_det,
    input wire logic i_hs_oc_det,
    input wire logic i_ls_oc_warn_det,
    input wire logic i_ov_fault_det,
    input wire logic i_overvoltage_warning_det,
    input wire logic i_uv_fault_det,
    input wire logic i_uv_warn_det,
    input wire logic i_feedback_sense_low,
    input wire logic i_feedback_sense_prebias,
    input wire logic i_pwm_cycle_tick,
    input wire logic i_cmd_wr,
    input wire logic i_cmd_rd,
    input wire logic [7:0] i_cmd_code,
    input wire logic [15:0] i_cmd_wdata,
    output logic [15:0] o_cmd_rdata,
    output logic o_cmd_rvalid,
    output logic o_pwm_run,
    output logic o_ls_force_on,
    output logic o_soft_start,
    output logic o_power_good_out,
    output logic o_power_good_oe,
    output logic o_smb_alert_out,
    output logic o_smb_alert_oe,
    output logic [1:0] o_high_side_current_trim,
    output logic [15:0] o_low_side_overcurrent_fault_limit,
    output logic [15:0] o_overtemperature_fault_limit,
    output logic [15:0] o_overtemperature_warning_limit,
    output logic [7:0] o_percent_window_limits
);
    // detectors are analog comparators, so every one passes two flops first
    logic [frpg_pkg::DET_W-1:0] det_raw;
    logic [frpg_pkg::DET_W-1:0] det_meta;
    logic [frpg_pkg::DET_W-1:0] det;
    assign det_raw = {i_converter_control_input, i_feedback_sense_prebias, i_feedback_sense_low, i_uv_warn_det,
                      i_uv_fault_det, i_overvoltage_warning_det, i_ov_fault_det, i_ls_oc_warn_det, i_hs_oc_det,
                      i_ls_oc_det, i_bandgap_ot_det, i_ot_warn_det, i_ot_cooled_det, i_ot_fault_det};

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            det_meta <= '0;
            det <= '0;
        end else begin
            det_meta <= det_raw;
            det <= det_meta;
        end
    end

    // register file
    logic [15:0] ls_oc_limit, overtemperature_fault_limit, overtemperature_warning_limit, config_reg;
    logic [7:0] pct_window, response;
    logic [frpg_pkg::STATUS_W-1:0] alert_mask, status;
    logic [15:0] next_ls_oc_limit, next_overtemperature_fault_limit, next_overtemperature_warning_limit, next_config_reg;
    logic [7:0] next_pct_window, next_response;
    logic [frpg_pkg::STATUS_W-1:0] next_alert_mask, next_status, status_set;
    logic [15:0] next_rdata;
    frpg_pkg::frpg_state_t state, next_state;

    logic [1:0] resp_ot, resp_oc, resp_ov, resp_uv;
    logic discharge_sel;
    logic [7:0] ramp_time;
    assign resp_ot = response[frpg_pkg::RESP_OT_LSB +: 2];
    assign resp_oc = response[frpg_pkg::RESP_OC_LSB +: 2];
    assign resp_ov = response[frpg_pkg::RESP_OV_LSB +: 2];
    assign resp_uv = response[frpg_pkg::RESP_UV_LSB +: 2];
    assign discharge_sel = config_reg[frpg_pkg::CFG_DISCHARGE_SEL_BIT];
    assign ramp_time = config_reg[frpg_pkg::CFG_RAMP_LSB +: 8];

    // the overvoltage warning flag also covers a feedback prebias above 5 percent
    logic ov_warn_now;
    assign ov_warn_now = det[frpg_pkg::D_OV_WARN] | det[frpg_pkg::D_PREBIAS];

    // writes by command code; status bits are write-one-to-clear with set winning
    always_comb begin
        next_ls_oc_limit = ls_oc_limit;
        next_overtemperature_fault_limit = overtemperature_fault_limit;
        next_overtemperature_warning_limit = overtemperature_warning_limit;
        next_pct_window = pct_window;
        next_response = response;
        next_config_reg = config_reg;
        next_alert_mask = alert_mask;
        next_status = status;
        if (i_cmd_wr) begin
            if (i_cmd_code == frpg_pkg::CODE_LS_OC_FAULT_LIMIT) begin
                next_ls_oc_limit = i_cmd_wdata;
            end else if (i_cmd_code == frpg_pkg::CODE_OVERTEMPERATURE_FAULT_LIMIT) begin
                next_overtemperature_fault_limit = i_cmd_wdata;
            end else if (i_cmd_code == frpg_pkg::CODE_OVERTEMPERATURE_WARNING_LIMIT) begin
                next_overtemperature_warning_limit = i_cmd_wdata;
            end else if (i_cmd_code == frpg_pkg::CODE_PERCENT_WINDOW) begin
                next_pct_window = i_cmd_wdata[7:0];
            end else if (i_cmd_code == frpg_pkg::CODE_RESPONSE_SETTINGS) begin
                next_response = i_cmd_wdata[7:0];
            end else if (i_cmd_code == frpg_pkg::CODE_CONVERTER_CONFIG) begin
                next_config_reg = i_cmd_wdata;
            end else if (i_cmd_code == frpg_pkg::CODE_ALERT_MASK) begin
                next_alert_mask = i_cmd_wdata[frpg_pkg::STATUS_W-1:0];
            end else if (i_cmd_code == frpg_pkg::CODE_FAULT_STATUS) begin
                next_status = status & ~i_cmd_wdata[frpg_pkg::STATUS_W-1:0];
            end
        end
        next_status = next_status | status_set;
        next_rdata = 16'h0000; // unmapped codes read zero
        if (i_cmd_code == frpg_pkg::CODE_LS_OC_FAULT_LIMIT) begin
            next_rdata = ls_oc_limit;
        end else if (i_cmd_code == frpg_pkg::CODE_OVERTEMPERATURE_FAULT_LIMIT) begin
            next_rdata = overtemperature_fault_limit;
        end else if (i_cmd_code == frpg_pkg::CODE_OVERTEMPERATURE_WARNING_LIMIT) begin
            next_rdata = overtemperature_warning_limit;
        end else if (i_cmd_code == frpg_pkg::CODE_PERCENT_WINDOW) begin
            next_rdata = {8'h00, pct_window};
        end else if (i_cmd_code == frpg_pkg::CODE_RESPONSE_SETTINGS) begin
            next_rdata = {8'h00, response};
        end else if (i_cmd_code == frpg_pkg::CODE_CONVERTER_CONFIG) begin
            next_rdata = config_reg;
        end else if (i_cmd_code == frpg_pkg::CODE_ALERT_MASK) begin
            next_rdata = {7'h00, alert_mask};
        end else if (i_cmd_code == frpg_pkg::CODE_FAULT_STATUS) begin
            next_rdata = {7'h00, status};
        end else if (i_cmd_code == frpg_pkg::CODE_SUPERVISOR_STATE) begin
            next_rdata = {10'h000, state};
        end
        if (!i_cmd_rd) begin
            next_rdata = o_cmd_rdata;
        end
    end

    // fault sequencing state, timers and overcurrent count
    logic [13:0] pre_cnt, next_pre_cnt;
    logic [10:0] unit_cnt, next_unit_cnt, ramp_units, target;
    logic [1:0] oc_cnt, next_oc_cnt;
    // cool_ot marks a stop by the programmable limit, which must wait for the 20 degree cooled flag
    logic ov_hold, next_ov_hold, cool_ot, next_cool_ot;
    logic active, oc_now, oc_trip, timer_done, bg_hot, ot_trip, ov_trip, uv_trip;
    localparam logic [1:0] OC_LAST = frpg_pkg::OC_PWM_COUNTS - 2'h1;
    assign ramp_units = (ramp_time == 8'h00) ? 11'h001 : {3'h0, ramp_time};
    assign target = (state == frpg_pkg::ST_RETRY) ? 11'(ramp_units * frpg_pkg::RETRY_RAMP_MULT) : ramp_units;
    assign timer_done = (unit_cnt >= target);
    assign active = (state == frpg_pkg::ST_START) || (state == frpg_pkg::ST_RUN);
    assign bg_hot = det[frpg_pkg::D_BG_OT];
    assign oc_now = det[frpg_pkg::D_LS_OC] | det[frpg_pkg::D_HS_OC];
    // third consecutive PWM count with overcurrent trips the fault
    assign oc_trip = i_pwm_cycle_tick && oc_now && (oc_cnt == OC_LAST);
    assign ot_trip = det[frpg_pkg::D_OT_FAULT] && (resp_ot != frpg_pkg::RESP_IGNORE);
    assign ov_trip = det[frpg_pkg::D_OV_FAULT] && (resp_ov != frpg_pkg::RESP_IGNORE);
    // undervoltage is blind while the ramp runs
    assign uv_trip = (state == frpg_pkg::ST_RUN) && det[frpg_pkg::D_UV_FAULT]
                     && (resp_uv != frpg_pkg::RESP_IGNORE);

    always_comb begin
        next_state = state;
        next_ov_hold = ov_hold;
        next_cool_ot = cool_ot;
        if (!det[frpg_pkg::D_CONVERTER_CONTROL_INPUT]) begin
            next_state = frpg_pkg::ST_IDLE; // control low is the only way out of a latch
        end else begin
            case (state)
                frpg_pkg::ST_IDLE: next_state = bg_hot ? frpg_pkg::ST_COOL : frpg_pkg::ST_START;
                frpg_pkg::ST_START, frpg_pkg::ST_RUN: begin
                    if (bg_hot) begin
                        next_state = frpg_pkg::ST_COOL;
                    end else if (ot_trip) begin
                        next_cool_ot = 1'b1;
                        next_state = (resp_ot == frpg_pkg::RESP_LATCH) ? frpg_pkg::ST_LATCH : frpg_pkg::ST_COOL;
                    end else if (oc_trip && resp_oc != frpg_pkg::RESP_IGNORE) begin
                        next_state = (resp_oc == frpg_pkg::RESP_LATCH) ? frpg_pkg::ST_LATCH : frpg_pkg::ST_RETRY;
                    end else if (ov_trip) begin
                        next_ov_hold = 1'b1;
                        next_state = (resp_ov == frpg_pkg::RESP_LATCH) ? frpg_pkg::ST_LATCH : frpg_pkg::ST_RETRY;
                    end else if (uv_trip) begin
                        next_state = (resp_uv == frpg_pkg::RESP_LATCH) ? frpg_pkg::ST_LATCH : frpg_pkg::ST_RETRY;
                    end else if (state == frpg_pkg::ST_START && timer_done) begin
                        next_state = frpg_pkg::ST_RUN;
                    end
                end
                frpg_pkg::ST_LATCH: next_state = frpg_pkg::ST_LATCH;
                frpg_pkg::ST_RETRY: begin
                    if (bg_hot) begin
                        next_state = frpg_pkg::ST_COOL;
                    end else if (timer_done) begin
                        next_state = frpg_pkg::ST_START;
                    end
                end
                frpg_pkg::ST_COOL: begin
                    // 20 degree hysteresis is flagged by the cooled detector
                    if (!bg_hot && (!cool_ot || det[frpg_pkg::D_OT_COOLED])) begin
                        next_state = frpg_pkg::ST_START;
                    end
                end
                default: next_state = frpg_pkg::ST_IDLE;
            endcase
        end
        if (next_state == frpg_pkg::ST_START || next_state == frpg_pkg::ST_IDLE) begin
            next_ov_hold = 1'b0;
            next_cool_ot = 1'b0;
        end
        // timers restart on every state change
        next_pre_cnt = 14'h0000;
        next_unit_cnt = 11'h000;
        if (next_state == state) begin
            next_pre_cnt = pre_cnt + 14'h0001;
            next_unit_cnt = unit_cnt;
            if (pre_cnt == 14'(RAMP_UNIT_CYCLES - 1)) begin
                next_pre_cnt = 14'h0000;
                next_unit_cnt = timer_done ? unit_cnt : unit_cnt + 11'h001;
            end
        end
        next_oc_cnt = oc_cnt;
        if (!active) begin
            next_oc_cnt = 2'h0;
        end else if (i_pwm_cycle_tick) begin
            next_oc_cnt = !oc_now ? 2'h0 : (oc_cnt == OC_LAST) ? oc_cnt : oc_cnt + 2'h1;
        end
    end

    // sticky events that feed the alert
    always_comb begin
        status_set = '0;
        status_set[frpg_pkg::S_OT_FAULT] = det[frpg_pkg::D_OT_FAULT];
        status_set[frpg_pkg::S_OT_WARN] = det[frpg_pkg::D_OT_WARN];
        status_set[frpg_pkg::S_BG_OT] = bg_hot;
        status_set[frpg_pkg::S_OC_FAULT] = oc_trip;
        status_set[frpg_pkg::S_LS_OC_WARN] = det[frpg_pkg::D_LS_OC_WARN];
        status_set[frpg_pkg::S_OV_FAULT] = det[frpg_pkg::D_OV_FAULT];
        status_set[frpg_pkg::S_OV_WARN] = ov_warn_now;
        status_set[frpg_pkg::S_UV_FAULT] = (state == frpg_pkg::ST_RUN) && det[frpg_pkg::D_UV_FAULT];
        status_set[frpg_pkg::S_UV_WARN] = (state == frpg_pkg::ST_RUN) && det[frpg_pkg::D_UV_WARN];
    end

    // outputs are computed from the next values so that every pin leaves a flop
    logic next_pwm_run, next_ls_force, next_pg_low, next_alert, pg_pull;
    always_comb begin
        // warnings never touch the switches; they pull power good (OT and LS OC ones unless set to ignore) and, through status bits, act on the alert
        pg_pull = ov_warn_now || det[frpg_pkg::D_UV_WARN] || det[frpg_pkg::D_OV_FAULT]
                  || det[frpg_pkg::D_UV_FAULT] || bg_hot || ot_trip
                  || (det[frpg_pkg::D_OT_WARN] && resp_ot != frpg_pkg::RESP_IGNORE)
                  || (det[frpg_pkg::D_LS_OC_WARN] && resp_oc != frpg_pkg::RESP_IGNORE);
        next_pg_low = (next_state != frpg_pkg::ST_RUN) || pg_pull;
        next_pwm_run = ((next_state == frpg_pkg::ST_START) || (next_state == frpg_pkg::ST_RUN))
                       && !next_ov_hold;
        // discharge either latches on or stops once feedback is below 0.2 V
        next_ls_force = next_ov_hold && !bg_hot
                        && (!discharge_sel || !det[frpg_pkg::D_FB_LOW]);
        next_alert = |(next_status & ~next_alert_mask);
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            ls_oc_limit <= frpg_pkg::LIMIT_RESET;
            overtemperature_fault_limit <= frpg_pkg::LIMIT_RESET;
            overtemperature_warning_limit <= frpg_pkg::LIMIT_RESET;
            pct_window <= frpg_pkg::PERCENT_WINDOW_RESET;
            response <= frpg_pkg::RESPONSE_RESET;
            config_reg <= frpg_pkg::CONFIG_RESET;
            alert_mask <= '0;
            status <= '0;
            o_cmd_rdata <= 16'h0000;
            o_cmd_rvalid <= 1'b0;
            state <= frpg_pkg::ST_IDLE;
            pre_cnt <= 14'h0000;
            unit_cnt <= 11'h000;
            oc_cnt <= 2'h0;
            ov_hold <= 1'b0;
            cool_ot <= 1'b0;
            o_pwm_run <= 1'b0;
            o_ls_force_on <= 1'b0;
            o_soft_start <= 1'b0;
            o_power_good_out <= 1'b0;
            o_power_good_oe <= 1'b1;
            o_smb_alert_out <= 1'b0;
            o_smb_alert_oe <= 1'b0;
            o_high_side_current_trim <= 2'h0;
            o_low_side_overcurrent_fault_limit <= frpg_pkg::LIMIT_RESET;
            o_overtemperature_fault_limit <= frpg_pkg::LIMIT_RESET;
            o_overtemperature_warning_limit <= frpg_pkg::LIMIT_RESET;
            o_percent_window_limits <= frpg_pkg::PERCENT_WINDOW_RESET;
        end else begin
            ls_oc_limit <= next_ls_oc_limit;
            overtemperature_fault_limit <= next_overtemperature_fault_limit;
            overtemperature_warning_limit <= next_overtemperature_warning_limit;
            pct_window <= next_pct_window;
            response <= next_response;
            config_reg <= next_config_reg;
            alert_mask <= next_alert_mask;
            status <= next_status;
            o_cmd_rdata <= next_rdata;
            o_cmd_rvalid <= i_cmd_rd;
            state <= next_state;
            pre_cnt <= next_pre_cnt;
            unit_cnt <= next_unit_cnt;
            oc_cnt <= next_oc_cnt;
            ov_hold <= next_ov_hold;
            cool_ot <= next_cool_ot;
            o_pwm_run <= next_pwm_run;
            o_ls_force_on <= next_ls_force;
            o_soft_start <= (next_state == frpg_pkg::ST_START);
            o_power_good_out <= 1'b0;
            o_power_good_oe <= next_pg_low;
            o_smb_alert_out <= 1'b0;
            o_smb_alert_oe <= next_alert;
            o_high_side_current_trim <= next_config_reg[frpg_pkg::CFG_TRIM_LSB +: 2];
            o_low_side_overcurrent_fault_limit <= next_ls_oc_limit;
            o_overtemperature_fault_limit <= next_overtemperature_fault_limit;
            o_overtemperature_warning_limit <= next_overtemperature_warning_limit;
            o_percent_window_limits <= next_pct_window;
        end
    end

    a_pg_startup_low: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (state != frpg_pkg::ST_RUN) |-> o_power_good_oe)
        else $error("power good released outside run");
    a_pg_window_low: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (det[frpg_pkg::D_UV_WARN] || ov_warn_now) |=> o_power_good_oe)
        else $error("power good released outside window");
    a_bandgap_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        bg_hot |=> !o_pwm_run && !o_ls_force_on && state != frpg_pkg::ST_RUN)
        else $error("switches active during bandgap overtemperature");
    a_ot_latch_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (active && !bg_hot && ot_trip && resp_ot == frpg_pkg::RESP_LATCH && det[frpg_pkg::D_CONVERTER_CONTROL_INPUT])
        |=> state == frpg_pkg::ST_LATCH)
        else $error("overtemperature latch-off missed");
    a_oc_three_counts: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (active && !bg_hot && !ot_trip && det[frpg_pkg::D_CONVERTER_CONTROL_INPUT] && oc_trip && resp_oc != frpg_pkg::RESP_IGNORE)
        |=> !o_pwm_run && state inside {frpg_pkg::ST_LATCH, frpg_pkg::ST_RETRY})
        else $error("overcurrent trip did not stop the switches");
    a_uv_ramp_blind: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (state == frpg_pkg::ST_START && !bg_hot && !ot_trip && !oc_trip && !ov_trip && det[frpg_pkg::D_CONVERTER_CONTROL_INPUT])
        |=> state inside {frpg_pkg::ST_START, frpg_pkg::ST_RUN})
        else $error("undervoltage acted on during ramp");
    a_alert_mask: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        o_smb_alert_oe == |(status & ~alert_mask))
        else $error("alert does not follow unmasked status");
    a_ot_default: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $fell(i_reset) |-> resp_ot == frpg_pkg::RESP_IGNORE)
        else $error("overtemperature response not ignore after reset");
    a_ov_discharge: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (active && !bg_hot && !ot_trip && !oc_trip && ov_trip && det[frpg_pkg::D_CONVERTER_CONTROL_INPUT] && !discharge_sel)
        |=> o_ls_force_on && !o_pwm_run)
        else $error("overvoltage discharge not applied");
endmodule

// [logic/frpg_pkg.sv]
package frpg_pkg;
    // command codes of the register map
    localparam logic [7:0] CODE_LS_OC_FAULT_LIMIT = 8'h46;
    localparam logic [7:0] CODE_OVERTEMPERATURE_FAULT_LIMIT = 8'h4F;
    localparam logic [7:0] CODE_OVERTEMPERATURE_WARNING_LIMIT = 8'h51;
    localparam logic [7:0] CODE_PERCENT_WINDOW = 8'hD7;
    localparam logic [7:0] CODE_RESPONSE_SETTINGS = 8'hE0;
    localparam logic [7:0] CODE_CONVERTER_CONFIG = 8'hE1;
    localparam logic [7:0] CODE_ALERT_MASK = 8'hE2;
    localparam logic [7:0] CODE_FAULT_STATUS = 8'hE3;
    localparam logic [7:0] CODE_SUPERVISOR_STATE = 8'hE4;

    // values after reset
    localparam logic [15:0] LIMIT_RESET = 16'h0000;
    localparam logic [7:0] PERCENT_WINDOW_RESET = 8'h00;
    localparam logic [7:0] RESPONSE_RESET = 8'h56; // ot ignore, oc/ov/uv restart
    localparam logic [15:0] CONFIG_RESET = 16'h0A06; // ramp 10 units, trim 3, latch-on discharge

    // two-bit response encoding and fields of the response register
    localparam logic [1:0] RESP_LATCH = 2'h0;
    localparam logic [1:0] RESP_RESTART = 2'h1;
    localparam logic [1:0] RESP_IGNORE = 2'h2;
    localparam int RESP_OT_LSB = 0;
    localparam int RESP_OC_LSB = 2;
    localparam int RESP_OV_LSB = 4;
    localparam int RESP_UV_LSB = 6;

    // fields of the converter configuration register
    localparam int CFG_DISCHARGE_SEL_BIT = 0;
    localparam int CFG_TRIM_LSB = 1;
    localparam int CFG_RAMP_LSB = 8;

    // detector inputs after the synchroniser
    localparam int DET_W = 14;
    localparam int D_OT_FAULT = 0;
    localparam int D_OT_COOLED = 1;
    localparam int D_OT_WARN = 2;
    localparam int D_BG_OT = 3;
    localparam int D_LS_OC = 4;
    localparam int D_HS_OC = 5;
    localparam int D_LS_OC_WARN = 6;
    localparam int D_OV_FAULT = 7;
    localparam int D_OV_WARN = 8;
    localparam int D_UV_FAULT = 9;
    localparam int D_UV_WARN = 10;
    localparam int D_FB_LOW = 11;
    localparam int D_PREBIAS = 12;
    localparam int D_CONVERTER_CONTROL_INPUT = 13;

    // sticky status bits, also the alert sources
    localparam int STATUS_W = 9;
    localparam int S_OT_FAULT = 0;
    localparam int S_OT_WARN = 1;
    localparam int S_BG_OT = 2;
    localparam int S_OC_FAULT = 3;
    localparam int S_LS_OC_WARN = 4;
    localparam int S_OV_FAULT = 5;
    localparam int S_OV_WARN = 6;
    localparam int S_UV_FAULT = 7;
    localparam int S_UV_WARN = 8;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int RAMP_UNIT_NS = 100000; // one soft-start ramp unit is 0.1 ms
    localparam int RAMP_UNIT_CYCLES = RAMP_UNIT_NS / CLK_PERIOD_NS;
    localparam logic [1:0] OC_PWM_COUNTS = 2'h3;
    localparam logic [10:0] RETRY_RAMP_MULT = 11'h007;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_START = 6'h02,
        ST_RUN = 6'h04,
        ST_LATCH = 6'h08,
        ST_RETRY = 6'h10,
        ST_COOL = 6'h20
    } frpg_state_t;
endpackage

// [testbench/frpg_downstream_model.sv]
module frpg_downstream_model (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_power_good_oe,
    output logic o_pg_line,
    output logic o_enabled
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up on the open-drain line: a released line reads high
    assign o_pg_line = i_power_good_oe ? 1'b0 : 1'b1;
    // second converter takes power good as its run control
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_enabled <= 1'b0;
        end else begin
            o_enabled <= o_pg_line;
        end
    end
endmodule

// [testbench/frpg_fault_supervisor_test.sv]
module frpg_fault_supervisor_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, tick = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
    logic [13:0] det = 14'h0000;
    logic [7:0] code = 8'h00;
    logic [7:0] pct;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic [1:0] trim;
    logic rv, run, lsf, ss, pg_oe, al_oe, pg_line, ds_en, pg_do, al_do;
    logic [15:0] ls_lim, ot_lim, otw_lim;
    int n_fail = 0, total_checks = 0, cyc = 0, n;
    // detector bits follow the package order, control in the top bit
    frpg_fault_supervisor #(.RAMP_UNIT_CYCLES(4)) i_frpg_fault_supervisor (.i_clk_sys(clk), .i_reset(rst),
        .i_converter_control_input(det[13]), .i_ot_fault_det(det[0]), .i_ot_cooled_det(det[1]),
        .i_ot_warn_det(det[2]), .i_bandgap_ot_det(det[3]), .i_ls_oc_det(det[4]), .i_hs_oc_det(det[5]),
        .i_ls_oc_warn_det(det[6]), .i_ov_fault_det(det[7]), .i_overvoltage_warning_det(det[8]),
        .i_uv_fault_det(det[9]), .i_uv_warn_det(det[10]), .i_feedback_sense_low(det[11]),
        .i_feedback_sense_prebias(det[12]), .i_pwm_cycle_tick(tick), .i_cmd_wr(wr_s), .i_cmd_rd(rd_s),
        .i_cmd_code(code), .i_cmd_wdata(wdata), .o_cmd_rdata(rdata), .o_cmd_rvalid(rv), .o_pwm_run(run),
        .o_ls_force_on(lsf), .o_soft_start(ss), .o_power_good_out(pg_do), .o_power_good_oe(pg_oe),
        .o_smb_alert_out(al_do), .o_smb_alert_oe(al_oe), .o_high_side_current_trim(trim),
        .o_low_side_overcurrent_fault_limit(ls_lim), .o_overtemperature_fault_limit(ot_lim),
        .o_overtemperature_warning_limit(otw_lim), .o_percent_window_limits(pct));
    frpg_downstream_model i_frpg_downstream_model (.i_clk_sys(clk), .i_reset(rst), .i_power_good_oe(pg_oe),
        .o_pg_line(pg_line), .o_enabled(ds_en));
    initial begin
        forever #5 clk = ~clk;
    end
    // a hang is cut short well past the expected few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            print_verdict();
        end
    end
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // run, low-side force, soft start, power good pull
    task outs(input logic [3:0] e);
        chk({12'h000, run, lsf, ss, pg_oe}, {12'h000, e});
    endtask
    task step(input int k);
        repeat (k) @(negedge clk);
    endtask
    task wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge clk);
        wr_s = 1'b1;
        code = c;
        wdata = d;
        @(negedge clk);
        wr_s = 1'b0;
    endtask
    // read data holds until the next read, so a late look is still valid
    task rd(input logic [7:0] c, input logic [15:0] e);
        @(negedge clk);
        rd_s = 1'b1;
        code = c;
        @(negedge clk);
        rd_s = 1'b0;
        chk({15'h0000, rv}, 16'h0001);
        chk(rdata, e);
    endtask
    task ticks(input int k);
        repeat (k) begin
            @(negedge clk);
            tick = 1'b1;
            @(negedge clk);
            tick = 1'b0;
        end
    endtask
    task wait_ss;
        n = 0;
        while (ss !== 1'b1 && n < 80) begin
            @(negedge clk);
            n++;
        end
    endtask
    initial begin
        step(4);
        rst = 1'b0;
        rd(8'hE0, 16'h0056);
        rd(8'h99, 16'h0000);
        wr(8'hD7, 16'h00A5);
        rd(8'hD7, 16'h00A5);
        chk({8'h00, pct}, 16'h00A5);
        wr(8'h4F, 16'h1234);
        rd(8'h4F, 16'h1234);
        chk(ot_lim, 16'h1234);
        wr(8'h46, 16'h0ABC);
        wr(8'h51, 16'h0DEF);
        chk(ls_lim, 16'h0ABC);
        chk(otw_lim, 16'h0DEF);
        wr(8'hE1, 16'h0102);
        chk({14'h0000, trim}, 16'h0001);
        det[13] = 1'b1;
        wait_ss();
        outs(4'b1011);
        step(10);
        outs(4'b1000);
        chk({14'h0000, pg_line, ds_en}, 16'h0003);
        det[12] = 1'b1;
        step(5);
        outs(4'b1001);
        det[12:0] = 13'h0401;
        step(5);
        outs(4'b1001);
        chk({15'h0000, al_oe}, 16'h0001);
        wr(8'hE2, 16'h01FF);
        chk({15'h0000, al_oe}, 16'h0000);
        det[12:0] = 13'h0010;
        step(3);
        ticks(2);
        outs(4'b1000);
        ticks(1);
        step(2);
        outs(4'b0001);
        det[4] = 1'b0;
        wait_ss();
        chk({15'h0000, n > 15 && n < 80}, 16'h0001);
        step(10);
        det[3] = 1'b1;
        step(5);
        outs(4'b0001);
        det[3] = 1'b0;
        wait_ss();
        chk({15'h0000, n < 80}, 16'h0001);
        wr(8'hE0, 16'h0055);
        step(10);
        det[2] = 1'b1;
        step(5);
        outs(4'b1001);
        det[2:0] = 3'b001;
        step(5);
        outs(4'b0001);
        det[0] = 1'b0;
        step(10);
        outs(4'b0001);
        det[1] = 1'b1;
        wait_ss();
        chk({15'h0000, n < 80}, 16'h0001);
        det[1] = 1'b0;
        wr(8'hE0, 16'h0052);
        step(10);
        det[2] = 1'b1;
        step(5);
        outs(4'b1000);
        det[2] = 1'b0;
        det[5] = 1'b1;
        step(3);
        ticks(3);
        step(40);
        outs(4'b0001);
        det[13] = 1'b0;
        det[5] = 1'b0;
        step(5);
        outs(4'b0001);
        det[13] = 1'b1;
        wait_ss();
        step(10);
        det[7] = 1'b1;
        step(5);
        outs(4'b0101);
        det[7] = 1'b0;
        wait_ss();
        outs(4'b1011);
        chk({15'h0000, n > 15}, 16'h0001);
        step(10);
        det[9] = 1'b1;
        step(5);
        outs(4'b0001);
        chk({14'h0000, pg_do, al_do}, 16'h0000);
        print_verdict();
    end
endmodule
